/* hdl/tmicp_pkg.sv */
// Package of constants, types and state layouts for the interval/capture/PWM timer
package tmicp_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTL0 = 8'h00;
   localparam logic [7:0] OFS_CTL2 = 8'h04;
   localparam logic [7:0] OFS_CCR0 = 8'h08;
   localparam logic [7:0] OFS_INV = 8'h0c;
   localparam logic [7:0] OFS_CYC = 8'h10;
   localparam logic [7:0] OFS_CNT = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTL0_RUN_BIT = 7;
   localparam int CTL0_MODE_LSB = 4;
   localparam int CTL0_CKS_LSB = 0;
   localparam int CTL2_ADEN_BIT = 1;
   localparam int CTL2_TRGS_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CTL0 = 8'h00;
   localparam logic [1:0] RST_CTL2 = 2'h0;
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [15:0] RST_CYC = 16'hffff;
   // Count clocks before a match in which a cycle write is deferred
   localparam logic [16:0] LATE_WINDOW = 17'h00002;
   localparam int DIV_W = 7;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TMICP_MODE_INTERVAL,
      TMICP_MODE_CAPTURE,
      TMICP_MODE_PWM,
      TMICP_MODE_RSVD
   } tmicp_mode_t;

   typedef enum logic [1:0] {
      TMICP_UPD_IDLE,
      TMICP_UPD_ARMED,
      TMICP_UPD_DEFER
   } tmicp_upd_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tmicp_bus_t;

   typedef struct packed {
      logic comp1;
      logic comp2;
      logic extInt;
   } tmicp_src_t;

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic tick;
   } tmicp_pre_state_t;

   typedef struct packed {
      logic [7:0] ctl0;
      logic [1:0] ctl2;
      logic [15:0] ccr0;
      logic [15:0] invShadow;
      logic [15:0] cycShadow;
      logic [15:0] invAct;
      logic [15:0] cycAct;
      tmicp_upd_t upd;
      logic [15:0] cnt;
      logic srcPrev;
      logic matchIrq;
      logic adcTrig;
      logic pwmOut;
      logic capEvt;
      logic [15:0] rdata;
   } tmicp_state_t;
endpackage : tmicp_pkg

/* hdl/tmicp_prescaler.sv */
// Count clock enable divider for the timer
`timescale 1ns/10ps
module tmicp_prescaler (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Control
   input wire logic enable,
   input wire logic [2:0] divSel,
   // Count clock enable pulse
   output logic tick
);
   tmicp_pkg::tmicp_pre_state_t state_reg;
   tmicp_pkg::tmicp_pre_state_t state_next;
   logic [tmicp_pkg::DIV_W-1:0] mask;

   always_comb begin
      state_next = state_reg;
      mask = ~({tmicp_pkg::DIV_W{1'b1}} << divSel);
      // Restart from zero so counting aligns to a fresh count clock
      if (!enable) begin
         state_next.div = '0;
         state_next.tick = 1'b0;
      end else begin
         state_next.div = state_reg.div + 1'b1;
         state_next.tick = ((state_reg.div & mask) == mask);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tick = state_reg.tick;
endmodule : tmicp_prescaler

/* hdl/tmicp_timer.sv */
// Top of the 16-bit interval, A/D trigger, capture and single PWM timer
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module tmicp_timer #(
   parameter int TIMER_ID = 0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register port
   input wire tmicp_pkg::tmicp_bus_t bus,
   output logic [15:0] rdata,
   // Capture sources
   input wire tmicp_pkg::tmicp_src_t src,
   // Events and output
   output logic matchInterrupt,
   output logic adcTrigger,
   output logic captureEvent,
   output logic pwmOut0
);
   tmicp_pkg::tmicp_state_t state_reg;
   tmicp_pkg::tmicp_state_t state_next;
   tmicp_pkg::tmicp_mode_t mode;
   logic tick;
   logic run;
   logic pwmMode;
   logic capMode;
   logic [15:0] per;
   logic match;
   logic late;
   logic capSrc;
   logic rise;
   logic loadNow;
   logic [15:0] invUse;
   logic [15:0] cycUse;
   logic wrCyc;

   // ----------------------------------------------------------------
   // Count clock
   // ----------------------------------------------------------------
   tmicp_prescaler u_prescaler (
      .mclk(mclk),
      .reset_n(reset_n),
      .enable(state_reg.ctl0[tmicp_pkg::CTL0_RUN_BIT]),
      .divSel(state_reg.ctl0[tmicp_pkg::CTL0_CKS_LSB +: 3]),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      run = state_reg.ctl0[tmicp_pkg::CTL0_RUN_BIT];
      mode = tmicp_pkg::tmicp_mode_t'(state_reg.ctl0[tmicp_pkg::CTL0_MODE_LSB +: 2]);
      pwmMode = (mode == tmicp_pkg::TMICP_MODE_PWM);
      capMode = (mode == tmicp_pkg::TMICP_MODE_CAPTURE);
      wrCyc = bus.wr && (bus.addr == tmicp_pkg::OFS_CYC);
      per = pwmMode ? state_reg.cycAct : state_reg.cycShadow;
      match = run && tick && (state_reg.cnt == per);
      late = (({1'b0, state_reg.cnt} + tmicp_pkg::LATE_WINDOW) >= {1'b0, per});
      if (TIMER_ID == 0) begin
         capSrc = state_reg.ctl2[tmicp_pkg::CTL2_TRGS_BIT] ? src.extInt : src.comp2;
      end else begin
         capSrc = src.comp1;
      end
      rise = capSrc && !state_reg.srcPrev;
      state_next.srcPrev = capSrc;
      loadNow = !run || (match && (state_reg.upd == tmicp_pkg::TMICP_UPD_ARMED));
      invUse = loadNow ? state_reg.invShadow : state_reg.invAct;
      cycUse = loadNow ? state_reg.cycShadow : state_reg.cycAct;

      // counter runs only with run bit
      if (!run) begin
         state_next.cnt = '0;
      end else if (tick) begin
         // clear after N, giving N plus one
         if (match) begin
            state_next.cnt = '0;
         end else begin
            state_next.cnt = state_reg.cnt + 16'h0001;
         end
      end

      if (!run) begin
         state_next.matchIrq = 1'b0;
         state_next.adcTrig = 1'b0;
      end else if (tick) begin
         state_next.matchIrq = match;
         state_next.adcTrig = state_reg.ctl2[tmicp_pkg::CTL2_ADEN_BIT] && !capMode &&
                              (state_reg.cnt == state_reg.ccr0) && (state_reg.ccr0 < per);
      end

      if (!run) begin
         state_next.upd = tmicp_pkg::TMICP_UPD_IDLE;
      end else if (match) begin
         case (state_reg.upd)
            tmicp_pkg::TMICP_UPD_ARMED: state_next.upd = tmicp_pkg::TMICP_UPD_IDLE;
            tmicp_pkg::TMICP_UPD_DEFER: state_next.upd = tmicp_pkg::TMICP_UPD_ARMED;
            default: state_next.upd = state_reg.upd;
         endcase
      end
      if (wrCyc && run) begin
         // late write waits one more match
         state_next.upd = late ? tmicp_pkg::TMICP_UPD_DEFER : tmicp_pkg::TMICP_UPD_ARMED;
      end
      // load takes the latest shadow values
      state_next.invAct = invUse;
      state_next.cycAct = cycUse;

      // high above inversion, low at equal
      if (!run || !pwmMode) begin
         state_next.pwmOut = 1'b0;
      end else if (tick) begin
         state_next.pwmOut = !match && ((state_reg.cnt + 16'h0001) > invUse);
      end

      // Register writes
      if (bus.wr) begin
         case (bus.addr)
            tmicp_pkg::OFS_CTL0: state_next.ctl0 = bus.wdata[7:0];
            tmicp_pkg::OFS_CTL2: begin
               state_next.ctl2[tmicp_pkg::CTL2_ADEN_BIT] = bus.wdata[tmicp_pkg::CTL2_ADEN_BIT];
               // select bit only on timer 0
               state_next.ctl2[tmicp_pkg::CTL2_TRGS_BIT] =
                  (TIMER_ID == 0) && bus.wdata[tmicp_pkg::CTL2_TRGS_BIT];
            end
            tmicp_pkg::OFS_CCR0: state_next.ccr0 = bus.wdata;
            tmicp_pkg::OFS_INV: state_next.invShadow = bus.wdata;
            tmicp_pkg::OFS_CYC: state_next.cycShadow = bus.wdata;
            default: state_next.ctl0 = state_next.ctl0;
         endcase
      end

      // capture wins over a register write
      state_next.capEvt = run && capMode && rise;
      if (run && capMode && rise) begin
         state_next.ccr0 = state_reg.cnt;
      end

      // Read data, valid the cycle after the strobe only
      state_next.rdata = '0;
      if (bus.rd) begin
         case (bus.addr)
            tmicp_pkg::OFS_CTL0: state_next.rdata = {8'h00, state_reg.ctl0};
            tmicp_pkg::OFS_CTL2: state_next.rdata = {14'h0000, state_reg.ctl2};
            tmicp_pkg::OFS_CCR0: state_next.rdata = state_reg.ccr0;
            tmicp_pkg::OFS_INV: state_next.rdata = state_reg.invShadow;
            tmicp_pkg::OFS_CYC: state_next.rdata = state_reg.cycShadow;
            tmicp_pkg::OFS_CNT: state_next.rdata = state_reg.cnt;
            default: state_next.rdata = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.ctl0 <= tmicp_pkg::RST_CTL0;
         state_reg.ctl2 <= tmicp_pkg::RST_CTL2;
         state_reg.ccr0 <= tmicp_pkg::RST_REG16;
         state_reg.invShadow <= tmicp_pkg::RST_REG16;
         state_reg.cycShadow <= tmicp_pkg::RST_CYC;
         state_reg.invAct <= tmicp_pkg::RST_REG16;
         state_reg.cycAct <= tmicp_pkg::RST_CYC;
         state_reg.upd <= tmicp_pkg::TMICP_UPD_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   assign matchInterrupt = state_reg.matchIrq;
   assign adcTrigger = state_reg.adcTrig;
   assign captureEvent = state_reg.capEvt;
   assign pwmOut0 = state_reg.pwmOut;
endmodule : tmicp_timer

/* test/tmicp_timer_chk.sv */
// Port assertions for the timer
`timescale 1ns/10ps
module tmicp_timer_chk #(
   parameter int TIMER_ID = 0
) (
   // Clock, reset and register port
   input wire logic mclk,
   input wire logic reset_n,
   input wire tmicp_pkg::tmicp_bus_t bus,
   input wire logic [15:0] rdata,
   // Sources and events
   input wire tmicp_pkg::tmicp_src_t src,
   input wire logic matchInterrupt,
   input wire logic adcTrigger,
   input wire logic captureEvent,
   input wire logic pwmOut0
);
   logic [7:0] ctl0_reg;
   logic [1:0] ctl2_reg;
   logic [15:0] ccr_reg, cyc_reg, gap_reg;
   logic gapOk_reg, sel, capMode, div0;
   assign sel = (TIMER_ID != 0) ? src.comp1 : (ctl2_reg[0] ? src.extInt : src.comp2);
   assign capMode = ctl0_reg[5:4] == 2'h1;
   assign div0 = ctl0_reg[2:0] == 3'h0;
   // Register mirror and match gap counter
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctl0_reg <= 8'h00;
         ctl2_reg <= 2'h0;
         ccr_reg <= 16'h0000;
         cyc_reg <= 16'hffff;
         gap_reg <= 16'h0000;
         gapOk_reg <= 1'b0;
      end else begin
         if (bus.wr && bus.addr == tmicp_pkg::OFS_CTL0) ctl0_reg <= bus.wdata[7:0];
         if (bus.wr && bus.addr == tmicp_pkg::OFS_CTL2) ctl2_reg <= bus.wdata[1:0];
         if (bus.wr && bus.addr == tmicp_pkg::OFS_CCR0) ccr_reg <= bus.wdata;
         if (bus.wr && bus.addr == tmicp_pkg::OFS_CYC) cyc_reg <= bus.wdata;
         gap_reg <= $rose(matchInterrupt) ? 16'h0001 : gap_reg + 16'h0001;
         gapOk_reg <= bus.wr ? 1'b0 : ($rose(matchInterrupt) | gapOk_reg);
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_stopClr;
      bus.wr && bus.addr == tmicp_pkg::OFS_CTL0 && !bus.wdata[7]
         |-> ##2 !pwmOut0 && !matchInterrupt && !adcTrigger;
   endproperty
   a_stopClr: assert property (p_stopClr) else $error("output after stop");
   property p_period;
      $rose(matchInterrupt) && gapOk_reg && div0 && ctl0_reg[5:4] != 2'h2
         |-> gap_reg == cyc_reg + 16'h0001;
   endproperty
   a_period: assert property (p_period) else $error("match interval wrong");
   property p_irqWidth;
      $rose(matchInterrupt) && div0 |=> !matchInterrupt;
   endproperty
   a_irqWidth: assert property (p_irqWidth) else $error("match pulse too long");
   property p_trigGate;
      $rose(adcTrigger) |-> $past(ctl2_reg[1]);
   endproperty
   a_trigGate: assert property (p_trigGate) else $error("trigger while disabled");
   property p_trigApart;
      adcTrigger |-> !matchInterrupt;
   endproperty
   a_trigApart: assert property (p_trigApart) else $error("trigger on match");
   property p_trigOrder;
      $rose(adcTrigger) |-> $past(ccr_reg) < $past(cyc_reg);
   endproperty
   a_trigOrder: assert property (p_trigOrder) else $error("trigger past period");
   property p_trigPlace;
      $rose(adcTrigger) && gapOk_reg && div0 |-> gap_reg == ccr_reg + 16'h0001;
   endproperty
   a_trigPlace: assert property (p_trigPlace) else $error("trigger misplaced");
   property p_capSrc;
      captureEvent |-> $past(capMode) && $past(sel) && !$past(sel, 2);
   endproperty
   a_capSrc: assert property (p_capSrc) else $error("capture without source rise");
endmodule : tmicp_timer_chk

bind tmicp_timer tmicp_timer_chk #(.TIMER_ID(TIMER_ID)) u_tmicp_timer_chk (.mclk(mclk),
   .reset_n(reset_n), .bus(bus), .rdata(rdata), .src(src), .matchInterrupt(matchInterrupt),
   .adcTrigger(adcTrigger), .captureEvent(captureEvent), .pwmOut0(pwmOut0));

/* test/tmicp_far_model.sv */
// Comparators, external input and A/D converter beside the timer
`timescale 1ns/10ps
module tmicp_far_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Requests and trigger
   input wire logic [2:0] raise,
   input wire logic adcTrigger,
   // Source levels and A/D start count
   output tmicp_pkg::tmicp_src_t src,
   output int adcStarts
);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         src <= '0;
         adcStarts <= 0;
      end else begin
         src <= tmicp_pkg::tmicp_src_t'(raise);
         if ($rose(adcTrigger)) adcStarts <= adcStarts + 1;
      end
   end
endmodule : tmicp_far_model

/* test/tb_top.sv */
// Self-checking bench for the timer
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin badCount++; \
   $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   tmicp_pkg::tmicp_bus_t bus = '0;
   logic [15:0] rdata, d, e;
   logic [2:0] raise = 3'h0;
   tmicp_pkg::tmicp_src_t src;
   logic matchInterrupt, adcTrigger, captureEvent, pwmOut0;
   int adcStarts, n, m, j, g, s;
   int badCount = 0;
   int checked = 0;
   int cycles = 0;
   tmicp_timer #(.TIMER_ID(0)) u_tmicp_timer (.mclk(mclk), .reset_n(reset_n), .bus(bus),
      .rdata(rdata), .src(src), .matchInterrupt(matchInterrupt), .adcTrigger(adcTrigger),
      .captureEvent(captureEvent), .pwmOut0(pwmOut0));
   tmicp_far_model u_tmicp_far_model (.mclk(mclk), .reset_n(reset_n), .raise(raise),
      .adcTrigger(adcTrigger), .src(src), .adcStarts(adcStarts));
   initial forever #25 mclk = ~mclk;
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         badCount++;
         end_sim();
      end
   end
   task automatic wr(input logic [7:0] a, input int v);
      @(posedge mclk);
      bus <= '{addr: a, wdata: v[15:0], wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      @(posedge mclk);
      v = rdata;
   endtask : rd
   // Rise to rise, so wide pulses of a divided count clock count once
   task automatic gapMatch(output int c);
      c = 0;
      do @(posedge mclk); while (matchInterrupt !== 1'b1);
      do begin
         @(posedge mclk);
         c++;
      end while (matchInterrupt !== 1'b0);
      do begin
         @(posedge mclk);
         c++;
      end while (matchInterrupt !== 1'b1);
   endtask : gapMatch
   function automatic int pwmHigh(input int c, input int a);
      return (a >= c) ? 0 : c - a;
   endfunction : pwmHigh
   task automatic pwmCheck(input int c, input int a);
      int hi;
      hi = 0;
      gapMatch(g);
      `CHK(g, c + 1);
      repeat (c + 1) begin
         @(posedge mclk);
         if (pwmOut0 === 1'b1) hi++;
      end
      `CHK(hi, pwmHigh(c, a));
   endtask : pwmCheck
   task automatic watchCap(input logic [2:0] r, output int c);
      raise <= 3'h0;
      repeat (3) @(posedge mclk);
      raise <= r;
      c = 0;
      repeat (5) begin
         @(posedge mclk);
         if (captureEvent === 1'b1) c++;
      end
   endtask : watchCap
   initial begin
      void'($urandom(32'h259fce5b));
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      rd(tmicp_pkg::OFS_CYC, d);
      `CHK(d, tmicp_pkg::RST_CYC);
      rd(8'h3c, d);
      `CHK(d, 16'h0000);
      n = $urandom_range(30, 6);
      wr(tmicp_pkg::OFS_CYC, n);
      wr(tmicp_pkg::OFS_CTL0, 32'h80);
      gapMatch(g);
      `CHK(g, n + 1);
      rd(tmicp_pkg::OFS_CNT, d);
      rd(tmicp_pkg::OFS_CNT, e);
      `CHK(e, 16'((32'(d) + 3) % (n + 1)));
      // Divided count clock, mode 3 as interval
      s = $urandom_range(3, 1);
      wr(tmicp_pkg::OFS_CTL0, 0);
      wr(tmicp_pkg::OFS_CTL0, 32'hb0 | s);
      gapMatch(g);
      `CHK(g, (n + 1) << s);
      wr(tmicp_pkg::OFS_CTL0, 32'h80);
      for (int k = 0; k < 3; k++) begin
         m = (k == 0) ? $urandom_range(n - 1, 0) : ((k == 1) ? n : 0);
         wr(tmicp_pkg::OFS_CCR0, m);
         wr(tmicp_pkg::OFS_CTL2, (k == 2) ? 0 : 2);
         gapMatch(g);
         j = adcStarts;
         gapMatch(g);
         `CHK(adcStarts - j, (k == 0) ? 2 : 0);
      end
      wr(tmicp_pkg::OFS_CTL0, 32'h90);
      j = $urandom_range(n - 3, 0);
      do @(posedge mclk); while (matchInterrupt !== 1'b1);
      repeat (j) @(posedge mclk);
      raise <= 3'h2;
      repeat (4) @(posedge mclk);
      rd(tmicp_pkg::OFS_CCR0, d);
      `CHK(d, 16'(j + 2));
      watchCap(3'h5, s);
      `CHK(s, 0);
      wr(tmicp_pkg::OFS_CTL2, 1);
      rd(tmicp_pkg::OFS_CTL2, d);
      `CHK(d, 16'h0001);
      watchCap(3'h1, s);
      `CHK(s, 1);
      for (int k = 0; k < 3; k++) begin
         n = $urandom_range(20, 3);
         m = (k == 2) ? n : $urandom_range(n, 0);
         wr(tmicp_pkg::OFS_CTL0, 0);
         wr(tmicp_pkg::OFS_INV, m);
         wr(tmicp_pkg::OFS_CYC, n);
         wr(tmicp_pkg::OFS_CTL0, 32'ha0);
         pwmCheck(n, m);
      end
      wr(tmicp_pkg::OFS_INV, $urandom_range(n, 0));
      m = $urandom_range(n - 1, 0);
      wr(tmicp_pkg::OFS_INV, m);
      wr(tmicp_pkg::OFS_CYC, n);
      gapMatch(g);
      pwmCheck(n, m);
      // Early cycle write loads at next match, late one a match later
      n = $urandom_range(20, 8);
      wr(tmicp_pkg::OFS_CTL0, 0);
      wr(tmicp_pkg::OFS_INV, 0);
      wr(tmicp_pkg::OFS_CYC, n);
      wr(tmicp_pkg::OFS_CTL0, 32'ha0);
      for (int k = 0; k < 2; k++) begin
         s = $urandom_range(20, 8);
         gapMatch(g);
         repeat ((k == 0) ? 0 : n - 3) @(posedge mclk);
         wr(tmicp_pkg::OFS_CYC, s);
         gapMatch(g);
         `CHK(g, (k == 0) ? s + 1 : n + 1);
         gapMatch(g);
         `CHK(g, s + 1);
         n = s;
      end
      // Mid-run reset
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(tmicp_pkg::OFS_CYC, d);
      `CHK(d, tmicp_pkg::RST_CYC);
      rd(tmicp_pkg::OFS_CNT, d);
      `CHK(d, 16'h0000);
      `CHK(pwmOut0, 1'b0);
      end_sim();
   end
endmodule : tb_top
